// [inc/metering_cfg_pkg.sv]
package metering_cfg_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	// Printed indices are not word aligned, so byte address = index * 4
	localparam int ADDR_W = 20;
	localparam logic [15:0] IDX_MODE = 16'hE60E;
	localparam logic [15:0] IDX_GAIN = 16'hE60F;
	localparam logic [15:0] IDX_NOMINAL_VOLTAGE_VALUE = 16'hE620;
	localparam logic [15:0] IDX_STAT = 16'hE621;
	localparam logic [ADDR_W-1:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_GAIN = {2'h0, IDX_GAIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_NOMINAL_VOLTAGE_VALUE = {2'h0, IDX_NOMINAL_VOLTAGE_VALUE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

	// ------------------------------------------------------------
	// Widths and field positions
	// ------------------------------------------------------------
	localparam int REG_W = 16;
	localparam int NOMINAL_VOLTAGE_VALUE_W = 24;
	localparam int CODE_W = 3;
	localparam int SHIFT_W = 3;
	localparam int MODE_ANGLE_LSB = 9;
	localparam int MODE_NOMINAL_VOLTAGE_VALUE_A = 11;
	localparam int MODE_FREQ = 14;
	localparam int GAIN_PHASE_CURR_LSB = 0;
	localparam int GAIN_NEUT_CURR_LSB = 3;
	localparam int GAIN_PHASE_VOLT_LSB = 6;
	localparam int GAIN_USED_W = 9;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [REG_W-1:0] MODE_RST = 16'h01FF;
	localparam logic [REG_W-1:0] GAIN_RST = 16'h0000;
	localparam logic [NOMINAL_VOLTAGE_VALUE_W-1:0] NOMINAL_VOLTAGE_VALUE_RST = 24'h000000;
	localparam logic [CODE_W-1:0] GAIN_CODE_UNITY = 3'h0;
	localparam logic [31:0] READ_ZERO = 32'h00000000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Angle measurement selection, in code order 00..11
	typedef enum logic [1:0] {
		ANG_VOLT_CURR,
		ANG_VOLT_VOLT,
		ANG_CURR_CURR,
		ANG_NONE
	} angle_mode_t;

	// Register targeted by an APB address
	typedef enum logic [2:0] {
		SEL_MODE,
		SEL_GAIN,
		SEL_NOMINAL_VOLTAGE_VALUE,
		SEL_STAT,
		SEL_NONE
	} reg_sel_t;

	// One rms voltage per phase, index 0 = A
	typedef logic [2:0][NOMINAL_VOLTAGE_VALUE_W-1:0] phase_volt_t;

	// Angle pairings handed to the phase-angle unit
	typedef struct packed {
		logic voltCurr;
		logic voltVolt;
		logic currCurr;
	} angle_ctrl_t;

	// Amplifier gains as left shifts, 0 = x1 .. 4 = x16
	typedef struct packed {
		logic [SHIFT_W-1:0] phaseVolt;
		logic [SHIFT_W-1:0] neutCurr;
		logic [SHIFT_W-1:0] phaseCurr;
	} gain_ctrl_t;

endpackage : metering_cfg_pkg

// [hdl/gain_code_decode.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Gain code to shift decode
// ------------------------------------------------------------
module gain_code_decode (
	input wire logic [metering_cfg_pkg::CODE_W-1:0] code,
	output logic [metering_cfg_pkg::SHIFT_W-1:0] shift
);

	// Codes 000..100 are x1..x16; reserved codes fall back to unity
	always_comb begin
		unique case (code)
			3'h1: shift = 3'h1;
			3'h2: shift = 3'h2;
			3'h3: shift = 3'h3;
			3'h4: shift = 3'h4;
			// Covers 000 and reserved 101..111
			default: shift = 3'h0;
		endcase
	end

endmodule : gain_code_decode

// [hdl/metering_gain_mode_config.sv]
// Local design decision: the APB register port.
`timescale 1ns/1ps
// Function
// - code 00 voltage-current, 01 voltage-voltage angles
// - code 10 current-current, 11 no angles
// - bit 11 substitutes nominal voltage, phase A
// - bit 12 substitutes nominal voltage, phase B
// - bit 13 substitutes nominal voltage, phase C
// - mode bit 15 resets zero, no function
// - phase current gain codes, reserved act unity
// - neutral gain same mapping, reserved act unity
// - neutral gain forced zero without neutral channel
// - phase voltage gain codes, reserved act unity
// - gain bits 15:9 reset zero, no effect
// - all gain fields reset to unity
module metering_gain_mode_config #(
	// Build variant: 1 when a neutral current channel exists
	parameter bit NEUTRAL_PRESENT = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [metering_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire metering_cfg_pkg::phase_volt_t measVrms,
	output metering_cfg_pkg::phase_volt_t usedVrms,
	output logic [2:0] voltInputIgnore,
	output metering_cfg_pkg::angle_ctrl_t angleCtrl,
	output logic lineFreq60,
	output metering_cfg_pkg::gain_ctrl_t gainCtrl
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Address to register select, shared by write and read paths
	function automatic metering_cfg_pkg::reg_sel_t decodeAddr(
		input logic [metering_cfg_pkg::ADDR_W-1:0] addr
	);
		metering_cfg_pkg::reg_sel_t sel;
		sel = metering_cfg_pkg::SEL_NONE;
		if (addr == metering_cfg_pkg::ADDR_MODE) begin
			sel = metering_cfg_pkg::SEL_MODE;
		end else if (addr == metering_cfg_pkg::ADDR_GAIN) begin
			sel = metering_cfg_pkg::SEL_GAIN;
		end else if (addr == metering_cfg_pkg::ADDR_NOMINAL_VOLTAGE_VALUE) begin
			sel = metering_cfg_pkg::SEL_NOMINAL_VOLTAGE_VALUE;
		end else if (addr == metering_cfg_pkg::ADDR_STAT) begin
			sel = metering_cfg_pkg::SEL_STAT;
		end
		return sel;
	endfunction : decodeAddr

	// Byte-lane merge: only lanes with their strobe set change
	function automatic logic [31:0] mergeLanes(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeLanes

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	// Stored computation mode word
	logic [metering_cfg_pkg::REG_W-1:0] mode_q;
	// Stored gain word
	logic [metering_cfg_pkg::REG_W-1:0] gain_q;
	// Stored nominal voltage
	logic [metering_cfg_pkg::NOMINAL_VOLTAGE_VALUE_W-1:0] nominal_voltage_value_q;
	// Candidate next values after byte-lane merge
	logic [31:0] modeMerged;
	logic [31:0] gainMerged;
	logic [31:0] vnomMerged;
	// Gain word after the neutral field pin
	logic [metering_cfg_pkg::REG_W-1:0] gain_d;
	// APB handshake state
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	// Read data source, purely combinational
	logic [31:0] readMux;
	// Transfer phases
	logic accessWait;
	logic accessDone;
	logic wrEn;
	metering_cfg_pkg::reg_sel_t addrSel;
	// Decoded fields
	metering_cfg_pkg::angle_mode_t angleMode;
	logic [2:0] nomUse;
	// Decoded amplifier shifts, one per gain field
	logic [metering_cfg_pkg::SHIFT_W-1:0] shiftDec [3];
	// Output flops
	metering_cfg_pkg::phase_volt_t usedVrms_q;
	logic [2:0] voltInputIgnore_q;
	metering_cfg_pkg::angle_ctrl_t angleCtrl_q;
	logic lineFreq60_q;
	metering_cfg_pkg::gain_ctrl_t gainCtrl_q;

	// ------------------------------------------------------------
	// APB transfer phases
	// ------------------------------------------------------------
	// First access cycle waits; data is prepared for the second
	assign accessWait = psel & penable & ~pready_q;
	// Completing edge: the only edge where a write lands
	assign accessDone = psel & penable & pready_q;
	// Writes land only at the completing edge
	assign wrEn = accessDone & pwrite;
	// Address held by the master for the whole transfer
	assign addrSel = decodeAddr(paddr);

	// One wait state on every transfer; pready drops after completion
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			// No answer pending while in reset
			pready_q <= 1'b0;
		end else begin
			pready_q <= accessWait;
		end
	end

	// Error flag valid only alongside pready
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= accessWait & (addrSel == metering_cfg_pkg::SEL_NONE);
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Lane merge per register; lanes beyond the width are dropped
	assign modeMerged = mergeLanes({16'h0000, mode_q}, pwdata, pstrb);
	assign gainMerged = mergeLanes({16'h0000, gain_q}, pwdata, pstrb);
	assign vnomMerged = mergeLanes({8'h00, nominal_voltage_value_q}, pwdata, pstrb);

	// Neutral field pinned when the channel is absent
	always_comb begin
		gain_d = gainMerged[metering_cfg_pkg::REG_W-1:0];
		if (!NEUTRAL_PRESENT) begin
			gain_d[metering_cfg_pkg::GAIN_NEUT_CURR_LSB +: metering_cfg_pkg::CODE_W] =
				metering_cfg_pkg::GAIN_CODE_UNITY;
		end
	end

	// Mode word; all bits stored so software reads back what it wrote
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q <= metering_cfg_pkg::MODE_RST;
		end else if (wrEn && addrSel == metering_cfg_pkg::SEL_MODE) begin
			mode_q <= modeMerged[metering_cfg_pkg::REG_W-1:0];
		end
	end

	// Gain word; upper bits stored but drive nothing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gain_q <= metering_cfg_pkg::GAIN_RST;
		end else if (wrEn && addrSel == metering_cfg_pkg::SEL_GAIN) begin
			gain_q <= gain_d;
		end
	end

	// Nominal voltage used for substitution
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			nominal_voltage_value_q <= metering_cfg_pkg::NOMINAL_VOLTAGE_VALUE_RST;
		end else if (wrEn && addrSel == metering_cfg_pkg::SEL_NOMINAL_VOLTAGE_VALUE) begin
			// Lanes 0..2 only; lane 3 has no storage
			nominal_voltage_value_q <= vnomMerged[metering_cfg_pkg::NOMINAL_VOLTAGE_VALUE_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Read mux; unmapped and reserved space read as zero
	always_comb begin
		unique case (addrSel)
			metering_cfg_pkg::SEL_MODE: begin
				// Upper half reads zero
				readMux = {16'h0000, mode_q};
			end
			metering_cfg_pkg::SEL_GAIN: begin
				// Upper half reads zero
				readMux = {16'h0000, gain_q};
			end
			metering_cfg_pkg::SEL_NOMINAL_VOLTAGE_VALUE: begin
				// Top byte reads zero
				readMux = {8'h00, nominal_voltage_value_q};
			end
			metering_cfg_pkg::SEL_STAT: begin
				// Live view of what the datapath is actually using
				readMux = {19'h00000, angleMode, lineFreq60_q,
					NEUTRAL_PRESENT, gainCtrl_q};
			end
			default: begin
				// Unmapped space: zero, error flagged alongside
				readMux = metering_cfg_pkg::READ_ZERO;
			end
		endcase
	end

	// Read data captured in the wait cycle, held until the next read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata_q <= metering_cfg_pkg::READ_ZERO;
		end else if (accessWait && !pwrite) begin
			prdata_q <= readMux;
		end
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	// Two-bit selection maps straight onto the enum order
	assign angleMode = metering_cfg_pkg::angle_mode_t'(
		mode_q[metering_cfg_pkg::MODE_ANGLE_LSB +: 2]);
	// Per-phase substitution enables, A..C
	assign nomUse = mode_q[metering_cfg_pkg::MODE_NOMINAL_VOLTAGE_VALUE_A +: 3];

	// Angle pairing flags, registered toward the angle unit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			angleCtrl_q <= '{voltCurr: 1'b1, voltVolt: 1'b0, currCurr: 1'b0};
		end else begin
			unique case (angleMode)
				metering_cfg_pkg::ANG_VOLT_CURR: begin
					angleCtrl_q <= '{voltCurr: 1'b1, voltVolt: 1'b0, currCurr: 1'b0};
				end
				metering_cfg_pkg::ANG_VOLT_VOLT: begin
					angleCtrl_q <= '{voltCurr: 1'b0, voltVolt: 1'b1, currCurr: 1'b0};
				end
				metering_cfg_pkg::ANG_CURR_CURR: begin
					angleCtrl_q <= '{voltCurr: 1'b0, voltVolt: 1'b0, currCurr: 1'b1};
				end
				metering_cfg_pkg::ANG_NONE: begin
					angleCtrl_q <= '{voltCurr: 1'b0, voltVolt: 1'b0, currCurr: 1'b0};
				end
			endcase
		end
	end

	// Line frequency selection; software owns its correctness
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			// 50 Hz processing after reset
			lineFreq60_q <= 1'b0;
		end else begin
			lineFreq60_q <= mode_q[metering_cfg_pkg::MODE_FREQ];
		end
	end

	// ------------------------------------------------------------
	// Nominal voltage substitution, one lane per phase
	// ------------------------------------------------------------
	// The same voltage feeds apparent power and every rms consumer,
	// so one substituted value per phase keeps them consistent.
	// Takes effect one edge after the mode write lands
	for (genvar p = 0; p < 3; p++) begin : gSubst
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				// No substitution and zero voltage in reset
				usedVrms_q[p] <= metering_cfg_pkg::NOMINAL_VOLTAGE_VALUE_RST;
				voltInputIgnore_q[p] <= 1'b0;
			end else begin
				usedVrms_q[p] <= nomUse[p] ? nominal_voltage_value_q : measVrms[p];
				voltInputIgnore_q[p] <= nomUse[p];
			end
		end
	end

	// ------------------------------------------------------------
	// Amplifier gain decode
	// ------------------------------------------------------------
	// Field order: phase current, neutral current, phase voltage
	// Each field decodes on its own; no shared state
	for (genvar g = 0; g < 3; g++) begin : gGain
		// code to shift, reserved as unity
		gain_code_decode uDec (
			.code(gain_q[g*metering_cfg_pkg::CODE_W +: metering_cfg_pkg::CODE_W]),
			.shift(shiftDec[g])
		);
	end

	// Registered gains; upper gain bits are never looked at
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			// Every amplifier at unity after reset
			gainCtrl_q <= '0;
		end else begin
			// Follows the gain word every cycle
			gainCtrl_q.phaseCurr <= shiftDec[0];
			gainCtrl_q.neutCurr <= shiftDec[1];
			gainCtrl_q.phaseVolt <= shiftDec[2];
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Bus answers, straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	// Datapath controls, straight from flops, so no decode
	// glitch ever reaches the amplifiers or the rms path
	assign usedVrms = usedVrms_q;
	assign voltInputIgnore = voltInputIgnore_q;
	assign angleCtrl = angleCtrl_q;
	assign lineFreq60 = lineFreq60_q;
	assign gainCtrl = gainCtrl_q;

endmodule : metering_gain_mode_config

// [sim/metering_cfg_sva.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checks of the mode and gain registers
// ------------------------------------------------------------
module metering_cfg_sva #(
	parameter bit NEUTRAL_PRESENT = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [metering_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire metering_cfg_pkg::phase_volt_t measVrms,
	input wire metering_cfg_pkg::phase_volt_t usedVrms,
	input wire logic [2:0] voltInputIgnore,
	input wire metering_cfg_pkg::angle_ctrl_t angleCtrl,
	input wire logic lineFreq60,
	input wire metering_cfg_pkg::gain_ctrl_t gainCtrl
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Completed full-lane writes; outputs follow two edges later
	logic wrDone;
	logic modeWr;
	logic gainWr;
	assign wrDone = psel && penable && pready && pwrite && pstrb[1:0] == 2'h3;
	assign modeWr = wrDone && paddr == metering_cfg_pkg::ADDR_MODE;
	assign gainWr = wrDone && paddr == metering_cfg_pkg::ADDR_GAIN;
	// Reserved gain codes fall back to unity
	function automatic logic [2:0] dec(input logic [2:0] c);
		return (c > 3'h4) ? 3'h0 : c;
	endfunction : dec
	property p_ready_wait;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held high");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_angle_onehot;
		$onehot0(angleCtrl);
	endproperty
	a_angle_onehot: assert property (p_angle_onehot) else $error("angle pairing not one-hot");
	property p_angle;
		modeWr |-> ##2 angleCtrl == (3'h4 >> $past(pwdata[10:9], 2));
	endproperty
	a_angle: assert property (p_angle) else $error("angle pairing wrong");
	property p_freq;
		modeWr |-> ##2 lineFreq60 == $past(pwdata[14], 2);
	endproperty
	a_freq: assert property (p_freq) else $error("line frequency wrong");
	property p_ignore;
		modeWr |-> ##2 voltInputIgnore == $past(pwdata[13:11], 2);
	endproperty
	a_ignore: assert property (p_ignore) else $error("input ignore wrong");
	property p_meas_a;
		!voltInputIgnore[0] |-> usedVrms[0] == $past(measVrms[0]);
	endproperty
	a_meas_a: assert property (p_meas_a) else $error("phase A voltage not measured");
	property p_meas_b;
		!voltInputIgnore[1] |-> usedVrms[1] == $past(measVrms[1]);
	endproperty
	a_meas_b: assert property (p_meas_b) else $error("phase B voltage not measured");
	property p_meas_c;
		!voltInputIgnore[2] |-> usedVrms[2] == $past(measVrms[2]);
	endproperty
	a_meas_c: assert property (p_meas_c) else $error("phase C voltage not measured");
	property p_gain_pc;
		gainWr |-> ##2 gainCtrl.phaseCurr == dec($past(pwdata[2:0], 2));
	endproperty
	a_gain_pc: assert property (p_gain_pc) else $error("phase current gain wrong");
	property p_gain_nc;
		gainWr |-> ##2 gainCtrl.neutCurr == (NEUTRAL_PRESENT ? dec($past(pwdata[5:3], 2)) : 3'h0);
	endproperty
	a_gain_nc: assert property (p_gain_nc) else $error("neutral gain wrong");
	property p_gain_pv;
		gainWr |-> ##2 gainCtrl.phaseVolt == dec($past(pwdata[8:6], 2));
	endproperty
	a_gain_pv: assert property (p_gain_pv) else $error("phase voltage gain wrong");
	property p_reset_out;
		$fell(rst) |-> gainCtrl == 9'h000 && angleCtrl == 3'h4 && !lineFreq60;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not at reset state");
	// Main scenarios reached
	c_gain: cover property (gainWr);
	c_err: cover property (pslverr);
	c_subst_c: cover property (voltInputIgnore == 3'h4);
endmodule : metering_cfg_sva

bind metering_gain_mode_config metering_cfg_sva #(.NEUTRAL_PRESENT(NEUTRAL_PRESENT)) u_sva (
	.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
	.measVrms, .usedVrms, .voltInputIgnore, .angleCtrl, .lineFreq60, .gainCtrl
);

// [sim/tb_top.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register bench over APB
// ------------------------------------------------------------
module tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [19:0] paddr = 20'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	metering_cfg_pkg::phase_volt_t measVrms = '0;
	metering_cfg_pkg::phase_volt_t usedVrms;
	logic [2:0] voltInputIgnore;
	metering_cfg_pkg::angle_ctrl_t angleCtrl;
	logic lineFreq60;
	metering_cfg_pkg::gain_ctrl_t gainCtrl;
	logic [31:0] rdv;
	logic errv;
	int n_mismatch = 0;
	int check_count = 0;
	always #5 mclk = ~mclk;
	metering_gain_mode_config u_metering_gain_mode_config (
		.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .measVrms, .usedVrms, .voltInputIgnore, .angleCtrl, .lineFreq60, .gainCtrl
	);
	// Verdict and end of run
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// One transfer; request held until ready is seen, bounded wait
	task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Write, then let the outputs follow
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(32'(errv), 32'h0);
		repeat (2) @(posedge mclk);
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
		chk(32'(errv), 32'(e));
	endtask : rd
	initial begin
		logic [31:0] g;
		metering_cfg_pkg::phase_volt_t ev;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(metering_cfg_pkg::ADDR_MODE, 32'h000001FF, 1'b0);
		rd(metering_cfg_pkg::ADDR_GAIN, 32'h0, 1'b0);
		chk(32'(gainCtrl), 32'h0);
		chk(32'(lineFreq60), 32'h0);
		// Every angle code, with readback
		for (int c = 0; c < 4; c++) begin
			wr(metering_cfg_pkg::ADDR_MODE, 32'h01FF | (32'(c) << 9));
			chk(32'(angleCtrl), 32'h4 >> c);
			rd(metering_cfg_pkg::ADDR_MODE, 32'h01FF | (32'(c) << 9), 1'b0);
		end
		wr(metering_cfg_pkg::ADDR_MODE, 32'h4000);
		chk(32'(lineFreq60), 32'h1);
		// Reserved bit alone drives nothing
		wr(metering_cfg_pkg::ADDR_MODE, 32'h8000);
		chk({lineFreq60, voltInputIgnore, 25'h0, angleCtrl}, 32'h4);
		rd(metering_cfg_pkg::ADDR_MODE, 32'h8000, 1'b0);
		// Nominal substitution per phase while the input moves
		measVrms <= {24'h333333, 24'h222222, 24'h111111};
		wr(metering_cfg_pkg::ADDR_NOMINAL_VOLTAGE_VALUE, 32'h00ABCDEF);
		for (int p = 0; p < 3; p++) begin
			wr(metering_cfg_pkg::ADDR_MODE, 32'h0800 << p);
			measVrms[p] <= 24'h5A5A5A;
			repeat (2) @(posedge mclk);
			ev = measVrms;
			ev[p] = 24'hABCDEF;
			chk(32'(voltInputIgnore), 32'h1 << p);
			for (int q = 0; q < 3; q++)
				chk(32'(usedVrms[q]), 32'(ev[q]));
		end
		wr(metering_cfg_pkg::ADDR_MODE, 32'h0);
		chk(32'(usedVrms[2]), 32'h5A5A5A);
		// Every gain code in all fields, reserved bits set, upper half ignored
		for (int c = 0; c < 8; c++) begin
			g = 32'hFE00 | (32'(c) * 32'h49);
			wr(metering_cfg_pkg::ADDR_GAIN, 32'hFFFF0000 | g);
			chk(32'(gainCtrl), (c > 4) ? 32'h0 : 32'(c) * 32'h49);
			rd(metering_cfg_pkg::ADDR_GAIN, g, 1'b0);
		end
		rd(20'h00000, 32'h0, 1'b1);
		// Status view: angle code 3, 60 Hz, gains 4/4/3, neutral present
		wr(metering_cfg_pkg::ADDR_MODE, 32'h4600);
		wr(metering_cfg_pkg::ADDR_GAIN, 32'h0123);
		// Status is read-only: a write is dropped without error
		wr(metering_cfg_pkg::ADDR_STAT, 32'hFFFFFFFF);
		rd(metering_cfg_pkg::ADDR_STAT, 32'h1F23, 1'b0);
		summarize();
	end
endmodule : tb_top
